// ==== design/sfp_regs.svh ====
// Opcodes, timing figures and fixed values of the serial flash command sequencer
`ifndef SFP_REGS_SVH
`define SFP_REGS_SVH

// ==========================================================
// Opcodes
`define SFP_OP_WRITE_ENABLE 8'h06
`define SFP_OP_PAGE_PROGRAM 8'h02
`define SFP_OP_DEEP_SLEEP 8'hb9
`define SFP_OP_WAKE_SIG 8'hab
`define SFP_OP_ID_READ 8'h90
`define SFP_OP_DUAL_ID_READ 8'h92

// ==========================================================
// Frame layout
`define SFP_CNT_OPC_ONLY 4'h1
`define SFP_CNT_ADDR_LAST 4'h3
`define SFP_CNT_MODE_BYTE 4'h4
`define SFP_CNT_FIRST_DATA 4'h5
`define SFP_ID_DEV_FIRST 8'h01
`define SFP_CONT_KEY 2'h2

// ==========================================================
// Identity and array size (identity values are arbitrary)
`define SFP_MAKER_ID_DEF 8'h5a
`define SFP_DEVICE_ID_DEF 8'h3c
`define SFP_MEM_BYTES 24'h040000
`define SFP_PROT_UNIT 24'h001000

// ==========================================================
// Timing: clock rate, times in ns, counts in clock cycles
`define SFP_CLK_MHZ 125
`define SFP_T_PROG_NS 2000000
`define SFP_T_SLEEP_ENTRY_NS 3000
`define SFP_T_WAKE_NS 8000
`define SFP_T_WAKE_SIG_NS 8000
`define SFP_PROG_CYC ((`SFP_T_PROG_NS * `SFP_CLK_MHZ + 999) / 1000)
`define SFP_SLEEP_CYC ((`SFP_T_SLEEP_ENTRY_NS * `SFP_CLK_MHZ + 999) / 1000)
`define SFP_WAKE_CYC ((`SFP_T_WAKE_NS * `SFP_CLK_MHZ + 999) / 1000)
`define SFP_WAKE_SIG_CYC ((`SFP_T_WAKE_SIG_NS * `SFP_CLK_MHZ + 999) / 1000)

`endif

// ==== design/sfp_pkg.sv ====
// Types shared by the serial flash command sequencer
package sfp_pkg;

  // ==========================================================
  // Frame phase while selected
  typedef enum logic [2:0] {
    PH_OPC   = 3'b000,
    PH_ADDR  = 3'b001,
    PH_DATA  = 3'b010,
    PH_OUT   = 3'b011,
    PH_DADDR = 3'b100,
    PH_DOUT  = 3'b101,
    PH_SKIP  = 3'b110
  } sfp_phase_type;

  // ==========================================================
  // Device power and cycle state
  typedef enum logic [2:0] {
    DS_STANDBY = 3'b000,
    DS_PROGRAM = 3'b001,
    DS_ENTER   = 3'b010,
    DS_SLEEP   = 3'b011,
    DS_WAKE    = 3'b100
  } sfp_dev_type;

  // ==========================================================
  // Decoded command of the current frame
  typedef enum logic [2:0] {
    CM_NONE = 3'b000,
    CM_WEN  = 3'b001,
    CM_PROG = 3'b010,
    CM_SLP  = 3'b011,
    CM_SIG  = 3'b100,
    CM_ID   = 3'b101,
    CM_DID  = 3'b110
  } sfp_cmd_type;

  // One byte write towards the array
  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] data;
  } sfp_arr_wr_type;

  // Status flags shown to the rest of the chip
  typedef struct packed {
    logic write_in_progress;
    logic write_enable_latch;
    logic sleeping;
    logic continuous_mode;
  } sfp_status_type;

endpackage

// ==== design/sfp_page_mem.sv ====
// Page buffer memory with registered read data
module sfp_page_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  import sfp_pkg::*;

  logic [DW-1:0] cell_r [2**AW]; // Storage, no reset needed

  // ==========================================================
  // Write port
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      cell_r[wr_addr] <= wr_data;
    end
  end

  // Read port, data held until the next read
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= cell_r[rd_addr];
    end
  end
endmodule // sfp_page_mem

// ==== design/sfp_skid.sv ====
// Small FIFO with valid and ready on both sides
module sfp_skid #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  import sfp_pkg::*;

  localparam int AW = $clog2(DEPTH); // DEPTH is a power of two
  logic [WIDTH-1:0] slot_r [DEPTH]; // Entry storage
  logic [AW:0] wp_r; // Write pointer with wrap bit
  logic [AW:0] rp_r; // Read pointer with wrap bit
  logic push;
  logic pop;

  // Full when indexes match and wrap bits differ
  assign out_valid = (wp_r != rp_r);
  assign in_ready = (wp_r[AW-1:0] != rp_r[AW-1:0]) || (wp_r[AW] == rp_r[AW]);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = slot_r[rp_r[AW-1:0]];

  // ==========================================================
  // Storage
  always_ff @(posedge ref_clk) begin
    if (push) begin
      slot_r[wp_r[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule // sfp_skid

// ==== design/sfp_core.sv ====
// Serial flash command sequencer: page program, deep sleep and identifier reads
`include "sfp_regs.svh"

module sfp_core #(
  parameter int PROG_CYCLES = `SFP_PROG_CYC,
  parameter logic [23:0] MEM_BYTES = `SFP_MEM_BYTES,
  parameter logic [7:0] MAKER_ID = `SFP_MAKER_ID_DEF, // Value is arbitrary
  parameter logic [7:0] DEVICE_ID = `SFP_DEVICE_ID_DEF // Value is arbitrary
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic dual_line_0_in,
  output logic dual_line_0_out,
  output logic dual_line_0_oe,
  input wire logic dual_line_1_in,
  output logic dual_line_1_out,
  output logic dual_line_1_oe,
  input wire logic protect_bit_2,
  input wire logic protect_bit_1,
  input wire logic protect_bit_0,
  output sfp_pkg::sfp_arr_wr_type arr_wr,
  output logic arr_wr_valid,
  input wire logic arr_wr_ready,
  output sfp_pkg::sfp_status_type status
);
  import sfp_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic [3:0] pin_raw; // Select, clock, line 1, line 0
  logic [3:0] pin_f; // Filtered pin levels
  assign pin_raw = {cs_n, sclk, dual_line_1_in, dual_line_0_in};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      localparam logic IDLE_V = (g == 3); // Select idles high
      logic [2:0] sh_r; // Bit 0 is the first stage
      logic f_r; // Accepted level
      // A glitch shorter than two cycles never reaches the filtered level
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          sh_r <= {3{IDLE_V}};
          f_r <= IDLE_V;
        end else begin
          sh_r <= {sh_r[1:0], pin_raw[g]};
          if (sh_r[1] == sh_r[2]) begin
            f_r <= sh_r[2];
          end
        end
      end
      assign pin_f[g] = f_r;
    end
  endgenerate

  // ==========================================================
  // State
  sfp_phase_type phase_r; // Frame phase
  sfp_cmd_type cmd_r; // Command of this frame
  sfp_dev_type dev_r; // Power and cycle state
  logic cs_q_r; // Previous filtered select
  logic sclk_q_r; // Previous filtered clock
  logic [7:0] in_sr_r; // Input shift register
  logic [2:0] bit_r; // Bit slot inside the byte
  logic [3:0] cnt_r; // Whole bytes seen, saturating
  logic [23:0] addr_r; // Address collector
  logic [15:0] page_r; // Page being programmed
  logic [7:0] col_r; // Next column in the page
  logic [255:0] mask_r; // Columns written this frame
  logic wel_r; // Write enable latch
  logic cont_r; // Continuous mode armed
  logic dev_first_r; // Dual read starts with device id
  logic nxt_dev_r; // Next byte out is the device id
  logic [7:0] out_sr_r; // Output shift register
  logic [1:0] ocnt_r; // Output slot count
  logic [2:0] obit_r; // Output bit inside byte
  logic out0_r, out1_r, oe0_r, oe1_r; // Pin drivers
  logic [31:0] dly_r; // Delay down counter
  logic [8:0] idx_r; // Stream index, bit 8 is done
  logic rd_pend_r; // Page buffer read data ready

  // ==========================================================
  // Edges and decode wires
  logic sel, rise, fall, cs_rise, cs_fall, cont_start;
  logic dual_in, dual_out, byte_done, exact, addr_last, mode_byte;
  logic [7:0] sh_nxt;
  logic [23:0] addr_nxt;
  sfp_cmd_type op_cmd;
  logic prog_go, prot, load_out, first_dev, mem_we, obyte_end;
  logic go_wen, go_prog, go_sleep, go_wake, go_wake_sig;
  logic streaming, mem_re, buf_ready;
  logic [7:0] mem_q;
  sfp_arr_wr_type buf_in;

  // Decode an opcode against the device state; busy states decode nothing
  function automatic sfp_cmd_type decode(input logic [7:0] op, input sfp_dev_type dev);
    decode = CM_NONE;
    if (dev == DS_SLEEP) begin
      if (op == `SFP_OP_WAKE_SIG) begin
        decode = CM_SIG;
      end
    end else if (dev == DS_STANDBY) begin
      case (op)
        `SFP_OP_WRITE_ENABLE: decode = CM_WEN;
        `SFP_OP_PAGE_PROGRAM: decode = CM_PROG;
        `SFP_OP_DEEP_SLEEP: decode = CM_SLP;
        `SFP_OP_WAKE_SIG: decode = CM_SIG;
        `SFP_OP_ID_READ: decode = CM_ID;
        `SFP_OP_DUAL_ID_READ: decode = CM_DID;
        default: decode = CM_NONE;
      endcase
    end
  endfunction

  // Top part of the array, sized by the protect bits, is locked
  function automatic logic prot_hit(input logic [2:0] bp, input logic [23:0] a);
    logic [23:0] span;
    span = `SFP_PROT_UNIT << bp;
    if (bp == 3'h0) begin
      prot_hit = 1'b0;
    end else if (span >= MEM_BYTES) begin
      prot_hit = 1'b1;
    end else begin
      prot_hit = (a >= MEM_BYTES - span);
    end
  endfunction

  assign sel = ~pin_f[3];
  assign rise = sel & pin_f[2] & ~sclk_q_r;
  assign fall = sel & ~pin_f[2] & sclk_q_r;
  assign cs_rise = pin_f[3] & ~cs_q_r;
  assign cs_fall = ~pin_f[3] & cs_q_r;
  assign cont_start = cont_r & (dev_r == DS_STANDBY);
  assign dual_in = (phase_r == PH_DADDR);
  assign dual_out = (phase_r == PH_DOUT);
  assign sh_nxt = dual_in ? {in_sr_r[5:0], pin_f[1], pin_f[0]} : {in_sr_r[6:0], pin_f[0]};
  assign byte_done = rise & (bit_r == (dual_in ? 3'h3 : 3'h7));
  assign exact = (bit_r == 3'h0);
  assign addr_nxt = {addr_r[15:0], sh_nxt};
  assign addr_last = (cnt_r == `SFP_CNT_ADDR_LAST);
  assign mode_byte = dual_in & (cnt_r == `SFP_CNT_MODE_BYTE);
  assign op_cmd = decode(sh_nxt, dev_r);
  assign prog_go = (op_cmd == CM_PROG) & wel_r;
  assign prot = prot_hit({protect_bit_2, protect_bit_1, protect_bit_0}, addr_nxt);
  assign load_out = byte_done & (((phase_r == PH_ADDR) & addr_last & (cmd_r != CM_PROG)) | mode_byte);
  assign first_dev = (phase_r == PH_ADDR) ? ((cmd_r == CM_SIG) | (addr_nxt[7:0] == `SFP_ID_DEV_FIRST)) : dev_first_r;
  assign mem_we = byte_done & (phase_r == PH_DATA);
  assign obyte_end = (obit_r == (dual_out ? 3'h3 : 3'h7));

  // Commands execute only when select rises, on a byte boundary except for the signature read
  assign go_wen = cs_rise & exact & (cmd_r == CM_WEN) & (cnt_r == `SFP_CNT_OPC_ONLY);
  assign go_prog = cs_rise & exact & (cmd_r == CM_PROG) & (phase_r == PH_DATA) & (cnt_r >= `SFP_CNT_FIRST_DATA);
  assign go_sleep = cs_rise & exact & (cmd_r == CM_SLP) & (cnt_r == `SFP_CNT_OPC_ONLY);
  assign go_wake = cs_rise & exact & (dev_r == DS_SLEEP) & (cmd_r == CM_SIG) & (cnt_r == `SFP_CNT_OPC_ONLY);
  assign go_wake_sig = cs_rise & (dev_r == DS_SLEEP) & (cmd_r == CM_SIG) & (phase_r == PH_OUT);

  // ==========================================================
  // Bit and byte counting
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_q_r <= 1'b1;
      sclk_q_r <= 1'b0;
      in_sr_r <= 8'h00;
      bit_r <= 3'h0;
      cnt_r <= 4'h0;
    end else begin
      cs_q_r <= pin_f[3];
      sclk_q_r <= pin_f[2];
      if (cs_fall) begin
        bit_r <= 3'h0;
        cnt_r <= cont_start ? 4'h1 : 4'h0;
      end else if (rise) begin
        in_sr_r <= sh_nxt;
        bit_r <= byte_done ? 3'h0 : bit_r + 3'h1;
        if (byte_done && cnt_r != 4'hf) begin
          cnt_r <= cnt_r + 4'h1;
        end
      end
    end
  end

  // Frame phase and command, advanced at each whole byte
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_r <= PH_OPC;
      cmd_r <= CM_NONE;
    end else if (cs_fall) begin
      phase_r <= cont_start ? PH_DADDR : PH_OPC;
      cmd_r <= cont_start ? CM_DID : CM_NONE;
    end else if (byte_done) begin
      case (phase_r)
        PH_OPC: begin
          cmd_r <= (op_cmd == CM_PROG && !wel_r) ? CM_NONE : op_cmd;
          if (op_cmd == CM_DID) begin
            phase_r <= PH_DADDR;
          end else if (op_cmd == CM_ID || op_cmd == CM_SIG || prog_go) begin
            phase_r <= PH_ADDR;
          end else begin
            phase_r <= PH_SKIP;
          end
        end
        PH_ADDR: begin
          if (addr_last && cmd_r == CM_PROG) begin
            phase_r <= prot ? PH_SKIP : PH_DATA;
            cmd_r <= prot ? CM_NONE : CM_PROG;
          end else if (addr_last) begin
            phase_r <= PH_OUT;
          end
        end
        PH_DADDR: begin
          if (mode_byte) begin
            phase_r <= PH_DOUT;
          end
        end
        default: phase_r <= phase_r;
      endcase
    end
  end

  // Address capture, page column and continuous mode bits
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_r <= 24'h000000;
      page_r <= 16'h0000;
      col_r <= 8'h00;
      cont_r <= 1'b0;
      dev_first_r <= 1'b0;
    end else if (byte_done) begin
      addr_r <= addr_nxt;
      if (phase_r == PH_ADDR && addr_last && cmd_r == CM_PROG) begin
        page_r <= addr_nxt[23:8];
        col_r <= addr_nxt[7:0];
      end else if (mem_we) begin
        col_r <= col_r + 8'h01;
      end
      if (dual_in && addr_last) begin
        dev_first_r <= (sh_nxt == `SFP_ID_DEV_FIRST);
      end
      if (mode_byte) begin
        cont_r <= (sh_nxt[5:4] == `SFP_CONT_KEY);
      end
    end
  end

  // Written-column mask; a later byte at the same column simply overwrites
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_r <= '0;
    end else if (byte_done && phase_r == PH_OPC && prog_go) begin
      mask_r <= '0;
    end else if (mem_we) begin
      mask_r[col_r] <= 1'b1;
    end
  end

  // ==========================================================
  // Identifier output on falling edges, msb first
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_sr_r <= 8'h00;
      obit_r <= 3'h0;
      nxt_dev_r <= 1'b0;
      {out0_r, out1_r, oe0_r, oe1_r} <= 4'h0;
    end else if (cs_rise) begin
      {out0_r, out1_r, oe0_r, oe1_r} <= 4'h0;
    end else if (load_out) begin
      out_sr_r <= first_dev ? DEVICE_ID : MAKER_ID;
      obit_r <= 3'h0;
      nxt_dev_r <= (cmd_r == CM_SIG) | ~first_dev;
    end else if (fall && (phase_r == PH_OUT || dual_out)) begin
      out1_r <= out_sr_r[7];
      oe1_r <= 1'b1;
      out0_r <= dual_out & out_sr_r[6];
      oe0_r <= dual_out;
      if (obyte_end) begin
        out_sr_r <= nxt_dev_r ? DEVICE_ID : MAKER_ID;
        nxt_dev_r <= (cmd_r == CM_SIG) | ~nxt_dev_r;
        obit_r <= 3'h0;
      end else begin
        out_sr_r <= dual_out ? {out_sr_r[5:0], 2'h0} : {out_sr_r[6:0], 1'b0};
        obit_r <= obit_r + 3'h1;
      end
    end
  end

  assign dual_line_0_out = out0_r;
  assign dual_line_0_oe = oe0_r;
  assign dual_line_1_out = out1_r;
  assign dual_line_1_oe = oe1_r;

  // ==========================================================
  // Write enable latch: set by its command, cleared when a program starts
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wel_r <= 1'b0;
    end else if (go_wen) begin
      wel_r <= 1'b1;
    end else if (go_prog) begin
      wel_r <= 1'b0;
    end
  end

  // Device state; one counter serves every self-timed delay
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dev_r <= DS_STANDBY;
      dly_r <= 32'h0;
    end else begin
      case (dev_r)
        DS_STANDBY: begin
          if (go_prog) begin
            dev_r <= DS_PROGRAM;
            dly_r <= 32'(PROG_CYCLES - 1);
          end else if (go_sleep) begin
            dev_r <= DS_ENTER;
            dly_r <= 32'(`SFP_SLEEP_CYC - 1);
          end
        end
        DS_PROGRAM: begin
          if (dly_r != 32'h0) begin
            dly_r <= dly_r - 32'h1;
          end else if (idx_r[8] && !arr_wr_valid) begin
            dev_r <= DS_STANDBY;
          end
        end
        DS_ENTER: begin
          if (dly_r != 32'h0) begin
            dly_r <= dly_r - 32'h1;
          end else begin
            dev_r <= DS_SLEEP;
          end
        end
        DS_SLEEP: begin
          if (go_wake) begin
            dev_r <= DS_WAKE;
            dly_r <= 32'(`SFP_WAKE_CYC - 1);
          end else if (go_wake_sig) begin
            dev_r <= DS_WAKE;
            dly_r <= 32'(`SFP_WAKE_SIG_CYC - 1);
          end
        end
        DS_WAKE: begin
          if (dly_r != 32'h0) begin
            dly_r <= dly_r - 32'h1;
          end else begin
            dev_r <= DS_STANDBY;
          end
        end
        default: dev_r <= DS_STANDBY;
      endcase
    end
  end

  // ==========================================================
  // Program stream: walk the page, send only written columns
  assign streaming = (dev_r == DS_PROGRAM) & ~idx_r[8];
  assign mem_re = streaming & ~rd_pend_r & mask_r[idx_r[7:0]];
  assign buf_in = '{addr: {page_r, idx_r[7:0]}, data: mem_q};

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      idx_r <= 9'h100;
      rd_pend_r <= 1'b0;
    end else if (go_prog) begin
      idx_r <= 9'h000;
      rd_pend_r <= 1'b0;
    end else if (rd_pend_r) begin
      if (buf_ready) begin
        rd_pend_r <= 1'b0;
        idx_r <= idx_r + 9'h001;
      end
    end else if (mem_re) begin
      rd_pend_r <= 1'b1;
    end else if (streaming) begin
      idx_r <= idx_r + 9'h001;
    end
  end

  sfp_page_mem #(
    .AW(8),
    .DW(8)
  ) u_page (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .wr_en(mem_we),
    .wr_addr(col_r),
    .wr_data(sh_nxt),
    .rd_en(mem_re),
    .rd_addr(idx_r[7:0]),
    .rd_data(mem_q)
  );

  // A stalled array holds the stream, nothing is dropped
  sfp_skid #(
    .WIDTH($bits(sfp_arr_wr_type)),
    .DEPTH(2)
  ) u_buf (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .in_valid(rd_pend_r),
    .in_ready(buf_ready),
    .in_data(buf_in),
    .out_valid(arr_wr_valid),
    .out_ready(arr_wr_ready),
    .out_data(arr_wr)
  );

  assign status = '{
    write_in_progress: (dev_r == DS_PROGRAM),
    write_enable_latch: wel_r,
    sleeping: (dev_r == DS_SLEEP),
    continuous_mode: cont_r
  };
endmodule // sfp_core

// ==== tb/sfp_core_properties.sv ====
// Port checks for the serial flash command sequencer
module sfp_core_properties (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic dual_line_0_oe,
  input wire logic dual_line_1_oe,
  input wire sfp_pkg::sfp_arr_wr_type arr_wr,
  input wire logic arr_wr_valid,
  input wire logic arr_wr_ready,
  input wire sfp_pkg::sfp_status_type status
);
  timeunit 1ns;
  timeprecision 1ps;
  import sfp_pkg::*;
  // ==========================================================
  // One clock domain, so clock and reset are given once
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Select high long enough for the filter: drivers must be off
  property p_oe_off;
    cs_n [*8] |-> !dual_line_0_oe && !dual_line_1_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("line driven while deselected");
  // A stalled byte stays put, so no word is lost
  property p_hold;
    arr_wr_valid && !arr_wr_ready |=> arr_wr_valid && $stable(arr_wr);
  endproperty
  a_hold: assert property (p_hold) else $error("array byte changed while stalled");
  // Bytes stay in one page, in rising column order
  property p_order;
    arr_wr_valid && arr_wr_ready ##1 arr_wr_valid |->
      arr_wr.addr[23:8] == $past(arr_wr.addr[23:8]) && arr_wr.addr[7:0] > $past(arr_wr.addr[7:0]);
  endproperty
  a_order: assert property (p_order) else $error("array byte out of page or order");
  // Array writes only inside a program cycle
  property p_wr_busy;
    arr_wr_valid |-> status.write_in_progress;
  endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("array write outside program cycle");
  // A cycle starts only from a set latch, which it clears
  property p_start;
    $rose(status.write_in_progress) |-> $past(status.write_enable_latch) && !status.write_enable_latch;
  endproperty
  a_start: assert property (p_start) else $error("program start latch mismatch");
  // The self-timed cycle is never a glitch
  property p_min;
    $rose(status.write_in_progress) |=> status.write_in_progress [*8];
  endproperty
  a_min: assert property (p_min) else $error("program cycle too short");
  // Asleep means no program activity
  property p_asleep;
    status.sleeping |-> !status.write_in_progress && !arr_wr_valid;
  endproperty
  a_asleep: assert property (p_asleep) else $error("program activity while asleep");
  // Sleep is entered only after the entry delay with select high
  property p_entry;
    $rose(status.sleeping) |-> cs_n && $past(cs_n, 300);
  endproperty
  a_entry: assert property (p_entry) else $error("sleep entered too early");
  // Wake happens only on deselection
  property p_wake;
    $fell(status.sleeping) |-> cs_n && $past(cs_n, 2);
  endproperty
  a_wake: assert property (p_wake) else $error("wake without deselection");
  // Latch is set on deselection, never asleep or busy
  property p_latch;
    $rose(status.write_enable_latch) |-> cs_n && !status.sleeping && !status.write_in_progress;
  endproperty
  a_latch: assert property (p_latch) else $error("latch set at wrong time");
endmodule // sfp_core_properties

bind sfp_core sfp_core_properties u_sfp_core_properties (.ref_clk, .arst_n, .cs_n, .dual_line_0_oe,
  .dual_line_1_oe, .arr_wr, .arr_wr_valid, .arr_wr_ready, .status);

// ==== tb/sfp_host.sv ====
// Host serial controller model: framing and byte shifting
module sfp_host (
  input wire logic ref_clk,
  input wire logic out0,
  input wire logic oe0,
  input wire logic out1,
  input wire logic oe1,
  output logic cs_n,
  output logic sclk,
  output logic io0,
  output logic io1
);
  timeunit 1ns;
  timeprecision 1ps;
  logic h0 = 1'b0; // Host drive of line 0
  logic h1 = 1'b0; // Host drive of line 1
  // Wire level: the device wins while it enables its driver
  assign io0 = oe0 ? out0 : h0;
  assign io1 = oe1 ? out1 : h1;
  // Clock idles low between frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
  end
  // Wait n cycles, then step just past the edge
  task automatic hw(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Select edges kept clear of clock edges for the input filter
  task automatic sel(input logic on);
    hw(8);
    cs_n = !on;
    hw(8);
  endtask
  // One byte msb first; dual moves two bits a clock, line 1 the higher
  task automatic xfer(input logic [7:0] tx, input logic dual, output logic [7:0] rx);
    for (int i = 7; i >= 0; i -= dual ? 2 : 1) begin
      h1 = tx[i];
      h0 = dual ? tx[i-1] : tx[i];
      hw(8);
      rx[i] = io1;
      if (dual) rx[i-1] = io0;
      sclk = 1'b1;
      hw(8);
      sclk = 1'b0;
    end
  endtask
endmodule // sfp_host

// ==== tb/testbench.sv ====
// Self-checking bench for the serial flash command sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sfp_pkg::*;
  localparam logic [7:0] MAKER = 8'ha5; // Arbitrary value
  localparam logic [7:0] DEV = 8'h17; // Arbitrary value
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cs_n, sclk, io0, io1, out0, oe0, out1, oe1, arr_wr_valid;
  logic [2:0] prot = 3'h0;
  logic arr_wr_ready = 1'b0;
  logic [3:0] stall = 4'h0;
  sfp_arr_wr_type arr_wr;
  sfp_status_type status;
  logic [23:0] got_a[$];
  logic [7:0] got_d[$];
  logic [7:0] rx;
  int mismatches = 0;
  int compares = 0;
  initial forever #4 ref_clk = ~ref_clk;
  sfp_core #(.PROG_CYCLES(400), .MAKER_ID(MAKER), .DEVICE_ID(DEV)) u_sfp_core (.ref_clk(ref_clk), .arst_n(arst_n),
    .cs_n(cs_n), .sclk(sclk), .dual_line_0_in(io0), .dual_line_0_out(out0), .dual_line_0_oe(oe0),
    .dual_line_1_in(io1), .dual_line_1_out(out1), .dual_line_1_oe(oe1), .protect_bit_2(prot[2]),
    .protect_bit_1(prot[1]), .protect_bit_0(prot[0]), .arr_wr(arr_wr), .arr_wr_valid(arr_wr_valid),
    .arr_wr_ready(arr_wr_ready), .status(status));
  sfp_host u_sfp_host (.ref_clk(ref_clk), .out0(out0), .oe0(oe0), .out1(out1), .oe1(oe1), .cs_n(cs_n), .sclk(sclk),
    .io0(io0), .io1(io1));
  // Array side takes bytes but stalls four cycles in sixteen, so the buffer fills
  always @(posedge ref_clk) begin
    if (arr_wr_valid && arr_wr_ready) begin
      got_a.push_back(arr_wr.addr);
      got_d.push_back(arr_wr.data);
    end
    #1;
    stall = stall + 4'h1;
    arr_wr_ready = stall[3:2] != 2'h0;
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tx(input logic [7:0] b, input logic dual = 1'b0);
    u_sfp_host.xfer(b, dual, rx);
  endtask
  task automatic one(input logic [7:0] op);
    u_sfp_host.sel(1'b1);
    tx(op);
    u_sfp_host.sel(1'b0);
  endtask
  // Program n bytes; the msb of each byte marks a second lap of the page
  task automatic prog(input logic [23:0] addr, input int n, input logic we, input logic [7:0] busy_op);
    logic [7:0] ev[256];
    logic hit[256];
    logic [7:0] c;
    logic ok;
    int j;
    hit = '{default: 1'b0};
    j = 0;
    ok = we && n > 0 && prot == 3'h0;
    got_a.delete();
    got_d.delete();
    if (we) one(8'h06);
    u_sfp_host.sel(1'b1);
    tx(8'h02);
    for (int k = 2; k >= 0; k--) tx(addr[8*k +: 8]);
    for (int i = 0; i < n; i++) begin
      c = addr[7:0] + i[7:0];
      ev[c] = {i[8], i[6:0]};
      hit[c] = 1'b1;
      tx({i[8], i[6:0]});
    end
    u_sfp_host.sel(1'b0);
    chk(status[3:2], {ok, we && !ok});
    // Opcode sent while busy must be dropped
    if (busy_op != 8'h00) one(busy_op);
    for (int k = 0; k < 3000 && status.write_in_progress !== 1'b0; k++) @(posedge ref_clk);
    u_sfp_host.hw(400);
    if (ok) for (int k = 0; k < 256; k++) if (hit[k]) begin
      chk(got_a[j], {addr[23:8], k[7:0]});
      chk(got_d[j], ev[k]);
      j++;
    end
    chk(got_a.size(), j);
    chk(status, {1'b0, we && !ok, 2'b00});
  endtask
  task automatic end_sim();
    $display("Mismatches %0d, compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    #600000;
    mismatches++;
    end_sim();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    chk(status, 4'h0);
    #1;
    arst_n = 1'b1;
    u_sfp_host.hw(8);
    prog(24'h0001fe, 3, 1'b0, 8'h00);
    prog(24'h0001fe, 0, 1'b1, 8'h00);
    prot = 3'h7;
    prog(24'h0001fe, 3, 1'b1, 8'h00);
    prot = 3'h0;
    prog(24'h0001fe, 3, 1'b1, 8'hb9);
    prog(24'h002010, 258, 1'b1, 8'h00);
    one(8'hb9);
    chk(status.sleeping, 1'b0);
    u_sfp_host.hw(380);
    chk(status.sleeping, 1'b1);
    one(8'h06);
    chk(status, 4'h2);
    one(8'hab);
    chk(status, 4'h0);
    u_sfp_host.hw(1010);
    u_sfp_host.sel(1'b1);
    tx(8'hab);
    repeat (3) tx(8'h00);
    repeat (2) begin
      tx(8'h00);
      chk(rx, DEV);
    end
    u_sfp_host.sel(1'b0);
    // Single and dual id reads; the last frame rides on the continuous mode
    for (int a = 0; a < 4; a++) begin
      u_sfp_host.sel(1'b1);
      if (a < 3) tx(a < 2 ? 8'h90 : 8'h92);
      tx(8'h00, a > 1);
      tx(8'h00, a > 1);
      tx({7'h0, a[0]}, a > 1);
      if (a > 1) tx(a == 2 ? 8'h20 : 8'h00, 1'b1);
      for (int k = 0; k < 3; k++) begin
        tx(8'h00, a > 1);
        chk(rx, (a[0] ^ k[0]) ? DEV : MAKER);
      end
      u_sfp_host.sel(1'b0);
      chk(status.continuous_mode, a == 2);
    end
    end_sim();
  end
endmodule // testbench
